/* rtl/ect_map.svh */
`ifndef ECT_MAP_SVH
`define ECT_MAP_SVH

// ==================================================================
// Register offsets
`define ECT_OFS_CTL1 4'h0
`define ECT_OFS_CTL2 4'h1
`define ECT_OFS_STAT 4'h2
`define ECT_OFS_MVA 4'h3
`define ECT_OFS_MVB 4'h4
`define ECT_OFS_CNT 4'h5

// ==================================================================
// First control register fields
`define ECT_C1_MBIE 7
`define ECT_C1_MAIE 6
`define ECT_C1_WIE 5
`define ECT_C1_CLR_HI 4
`define ECT_C1_CLR_LO 3
`define ECT_C1_CK_HI 2
`define ECT_C1_CK_LO 0

// ==================================================================
// Second control register fields
`define ECT_C2_EDGE_HI 4
`define ECT_C2_EDGE_LO 3
`define ECT_C2_TRIGGER_MODE_ENABLE 2
`define ECT_C2_ICK 0
`define ECT_C2_RSV 8'hE2

// ==================================================================
// Status and control register fields
`define ECT_ST_FLAG_HI 7
`define ECT_ST_FLAG_LO 5
`define ECT_ST_ACTB_HI 3
`define ECT_ST_ACTB_LO 2
`define ECT_ST_ACTA_HI 1
`define ECT_ST_ACTA_LO 0
`define ECT_ST_RSV 8'h10

// ==================================================================
// Reset values and counter limits
`define ECT_BYTE_RST 8'h00
`define ECT_MVAL_RST 8'hFF
`define ECT_CNT_MAX 8'hFF
`define ECT_CNT_ONE 8'h01

// ==================================================================
// Encodings
`define ECT_ACT_NONE 2'h0
`define ECT_ACT_LOW 2'h1
`define ECT_ACT_HIGH 2'h2
`define ECT_ACT_TOG 2'h3
`define ECT_CLR_NONE 2'h0
`define ECT_CLR_A 2'h1
`define ECT_CLR_B 2'h2
`define ECT_CLR_PIN 2'h3
`define ECT_EDG_OFF 2'h0
`define ECT_EDG_RISE 2'h1
`define ECT_EDG_FALL 2'h2
`define ECT_EDG_BOTH 2'h3
`define ECT_CK_STOP 3'h0
`define ECT_CK_INT_A 3'h1
`define ECT_CK_INT_B 3'h2
`define ECT_CK_EXT_RISE 3'h3
`define ECT_CK_EXT_FALL 3'h4
`define ECT_CK_EXT_BOTH 3'h5

`endif

/* rtl/ect_pkg.sv */
// ==================================================================
// Shared types
package ect_pkg;
  typedef logic [7:0] ect_byte_t;
  typedef enum logic {ECT_RUN, ECT_HALT} ect_run_t;
endpackage

/* rtl/ect_sync.sv */
`timescale 1ns/1ps
// ==================================================================
// Three-stage pin synchroniser with agreement filter
module ect_sync
  #(parameter int W = 3)
  (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Pins and filtered levels
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_level
  );

  genvar g;
  generate
    for (g = 0; g < W; g++)
    begin : g_bit
      logic s1_ff;
      logic s2_ff;
      logic s3_ff;
      logic lvl_ff;
      // Pulses shorter than two clocks may be missed by the filter
      always_ff @(posedge i_clk or negedge i_arst_n)
      begin
        if (!i_arst_n)
        begin
          s1_ff <= 1'b0;
          s2_ff <= 1'b0;
          s3_ff <= 1'b0;
          lvl_ff <= 1'b0;
        end
        else
        begin
          s1_ff <= i_async[g];
          s2_ff <= s1_ff;
          s3_ff <= s2_ff;
          if (s2_ff == s3_ff)
          begin
            lvl_ff <= s3_ff; // R10
          end
        end
      end
      assign o_level[g] = lvl_ff;
    end
  endgenerate

endmodule // ect_sync

/* rtl/ect_timer.sv */
// Operation
// [R1] Six count clock choices, counting starts immediately
// [R2] Wrap from max to zero sets flag
// [R3] Wrap interrupt only when enabled
// [R4] Continuous compare sets match flags A, B
// [R5] Match event at last equal state
// [R6] Match interrupts only when enabled
// [R7] Match updates output pin per action
// [R8] Clear select 01/10 clears on match
// [R9] Clear select 11 clears on pin rise
// [R10] Reset pin pulses held 1.5 clocks; the agreement filter here needs two clocks
// [R11] Trigger mode halts counting after clear
// [R12] Selected trigger edge restarts counting
// [R13] Clear beats counter write
// [R14] Counter write beats increment
// [R15] Match value write suppresses that match
// [R16] Priority toggle, then high, then low
// [R17] Internal increment on divided clock fall
// [R18] Source switch may add one increment
// [R19] Clear on A gives free-running waveform
// [R20] Trigger mode gives delayed pulse
// [R21] Actions: none, low, high, toggle
// [R22] Output low after reset until match
// [R23] Flag clears by zero after read
// [R24] Edges: off, rise, fall, both
// [R25] Clear select 01 A, 10 B, 00 off
// [R26] Eight-bit counter and match values
//
// The register offsets and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
`include "ect_map.svh"
module ect_timer
  import ect_pkg::*;
  #(
  parameter int P_DIV_W = 8,
  parameter int P_TAP0 = 1,
  parameter int P_TAP1 = 2,
  parameter int P_TAP2 = 4
  )
  (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_ARST_N,
  // Register port
  input wire logic [3:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [7:0] O_RDATA,
  // Pins
  input wire logic I_EXT_CLK,
  input wire logic I_COUNTER_RESET_PIN,
  input wire logic I_TRIGGER_PIN,
  output logic O_TIMER_OUT_PIN,
  // Interrupt requests
  output logic O_IRQ_WRAP,
  output logic O_IRQ_MATCH_A,
  output logic O_IRQ_MATCH_B
  );

  // ================================================================
  // Declarations
  ect_byte_t ctl1_ff;
  logic [1:0] edge_sel_ff;
  logic trig_mode_enable_ff;
  logic internal_clock_pick_ff;
  logic [1:0] act_a_ff, act_b_ff;
  logic [2:0] flags_ff, arm_ff;
  ect_byte_t match_value_a_ff, match_value_b_ff;
  ect_byte_t up_counter_ff;
  ect_byte_t rdata_ff;
  logic out_ff;
  ect_run_t run_ff;
  logic [P_DIV_W-1:0] div_ff;
  logic int_prev_ff;
  logic [2:0] pin_prev_ff;
  logic [2:0] pin_lvl;
  logic seen_match_ff;

  // ================================================================
  // Pin synchronisers
  ect_sync #(.W(3)) u_sync
    (
    .i_clk(I_CLK),
    .i_arst_n(I_ARST_N),
    .i_async({I_EXT_CLK, I_COUNTER_RESET_PIN, I_TRIGGER_PIN}),
    .o_level(pin_lvl)
    );
  wire [2:0] pin_rise = pin_lvl & ~pin_prev_ff;
  wire [2:0] pin_fall = ~pin_lvl & pin_prev_ff;
  wire ext_rise = pin_rise[2];
  wire ext_fall = pin_fall[2];
  wire rst_rise = pin_rise[1];
  wire trg_rise = pin_rise[0];
  wire trg_fall = pin_fall[0];

  // ================================================================
  // Register decode
  wire wr_ctl1 = I_WR && (I_ADDR == `ECT_OFS_CTL1);
  wire wr_ctl2 = I_WR && (I_ADDR == `ECT_OFS_CTL2);
  wire wr_stat = I_WR && (I_ADDR == `ECT_OFS_STAT);
  wire wr_mva = I_WR && (I_ADDR == `ECT_OFS_MVA);
  wire wr_mvb = I_WR && (I_ADDR == `ECT_OFS_MVB);
  wire wr_cnt = I_WR && (I_ADDR == `ECT_OFS_CNT);
  wire rd_stat = I_RD && (I_ADDR == `ECT_OFS_STAT);
  wire [2:0] clk_pick = ctl1_ff[`ECT_C1_CK_HI:`ECT_C1_CK_LO];
  wire [1:0] clr_sel = ctl1_ff[`ECT_C1_CLR_HI:`ECT_C1_CLR_LO];
  wire [7:0] stat_rd = {flags_ff, 1'b0, act_b_ff, act_a_ff}
    | `ECT_ST_RSV;
  wire [7:0] ctl2_rd = {3'h0, edge_sel_ff, trig_mode_enable_ff, 1'b0,
    internal_clock_pick_ff} | `ECT_C2_RSV;

  // ================================================================
  // Count source selection
  // Free prescaler, so a source change can look like a falling edge
  wire [P_DIV_W-1:0] nxt_div = div_ff + {{(P_DIV_W-1){1'b0}}, 1'b1};
  wire int_sel = (clk_pick == `ECT_CK_INT_A)
    || (clk_pick == `ECT_CK_INT_B); // R1
  wire tap_a = internal_clock_pick_ff ? div_ff[P_TAP1] : div_ff[P_TAP0];
  wire int_clk = !int_sel ? 1'b0
    : (clk_pick == `ECT_CK_INT_A) ? tap_a : div_ff[P_TAP2];
  wire inc_int = int_sel && int_prev_ff && !int_clk; // R17 R18
  wire inc_ext = ((clk_pick == `ECT_CK_EXT_RISE) && ext_rise)
    || ((clk_pick == `ECT_CK_EXT_FALL) && ext_fall)
    || ((clk_pick == `ECT_CK_EXT_BOTH) && (ext_rise || ext_fall)); // R1
  wire running = (run_ff == ECT_RUN);
  wire tick = (inc_int || inc_ext) && running;

  // ================================================================
  // Compare, clear and wrap
  // Match fires as the counter leaves the equal value
  wire eq_a = (up_counter_ff == match_value_a_ff); // R26
  wire eq_b = (up_counter_ff == match_value_b_ff); // R26
  wire match_a = eq_a && tick && !wr_mva; // R4 R5 R15
  wire match_b = eq_b && tick && !wr_mvb; // R4 R5 R15
  wire clr_a = (clr_sel == `ECT_CLR_A) && match_a; // R8 R25 R19
  wire clr_b = (clr_sel == `ECT_CLR_B) && match_b; // R8 R25 R20
  wire clr_pin = (clr_sel == `ECT_CLR_PIN) && rst_rise; // R9
  wire clr_any = clr_a || clr_b || clr_pin;
  wire wrap_ev = tick && (up_counter_ff == `ECT_CNT_MAX)
    && !clr_any && !wr_cnt; // R2
  ect_byte_t nxt_up_counter;
  always_comb
  begin
    nxt_up_counter = up_counter_ff;
    if (clr_any)
      nxt_up_counter = `ECT_BYTE_RST; // R13
    else if (wr_cnt)
      nxt_up_counter = I_WDATA; // R14
    else if (tick)
      nxt_up_counter = up_counter_ff + `ECT_CNT_ONE;
  end

  // ================================================================
  // Trigger mode
  wire trg_edge = ((edge_sel_ff == `ECT_EDG_RISE) && trg_rise)
    || ((edge_sel_ff == `ECT_EDG_FALL) && trg_fall)
    || ((edge_sel_ff == `ECT_EDG_BOTH) && (trg_rise || trg_fall)); // R24
  ect_run_t nxt_run;
  always_comb
  begin
    nxt_run = run_ff;
    case (run_ff)
      ECT_RUN:
        if (trig_mode_enable_ff && clr_any)
          nxt_run = ECT_HALT; // R11
      ECT_HALT:
        if (!trig_mode_enable_ff)
          nxt_run = ECT_RUN;
        else if (trg_edge && !clr_any)
          nxt_run = ECT_RUN; // R12 R20
      default:
        nxt_run = ECT_RUN;
    endcase
  end

  // ================================================================
  // Output pin actions
  wire [1:0] eff_a = match_a ? act_a_ff : `ECT_ACT_NONE; // R7
  wire [1:0] eff_b = match_b ? act_b_ff : `ECT_ACT_NONE; // R7
  wire do_tog = (eff_a == `ECT_ACT_TOG) || (eff_b == `ECT_ACT_TOG);
  wire do_high = (eff_a == `ECT_ACT_HIGH) || (eff_b == `ECT_ACT_HIGH);
  wire do_low = (eff_a == `ECT_ACT_LOW) || (eff_b == `ECT_ACT_LOW);
  wire nxt_out = do_tog ? !out_ff
    : do_high ? 1'b1
    : do_low ? 1'b0 : out_ff; // R16 R21

  // ================================================================
  // Flags: set wins over clear
  wire [2:0] flag_set = {match_b, match_a, wrap_ev};
  wire [2:0] flag_clr = (wr_stat ? arm_ff : 3'h0)
    & ~I_WDATA[`ECT_ST_FLAG_HI:`ECT_ST_FLAG_LO]; // R23
  wire [2:0] nxt_flags = flag_set | (flags_ff & ~flag_clr);
  wire [2:0] nxt_arm = rd_stat ? flags_ff
    : wr_stat ? 3'h0 : arm_ff;

  // ================================================================
  // Read mux
  ect_byte_t nxt_rdata;
  always_comb
  begin
    nxt_rdata = `ECT_BYTE_RST;
    if (!I_RD)
      nxt_rdata = `ECT_BYTE_RST;
    else if (I_ADDR == `ECT_OFS_CTL1)
      nxt_rdata = ctl1_ff;
    else if (I_ADDR == `ECT_OFS_CTL2)
      nxt_rdata = ctl2_rd;
    else if (I_ADDR == `ECT_OFS_STAT)
      nxt_rdata = stat_rd;
    else if (I_ADDR == `ECT_OFS_MVA)
      nxt_rdata = match_value_a_ff;
    else if (I_ADDR == `ECT_OFS_MVB)
      nxt_rdata = match_value_b_ff;
    else if (I_ADDR == `ECT_OFS_CNT)
      nxt_rdata = up_counter_ff;
  end

  // ================================================================
  // Registers
  always_ff @(posedge I_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      ctl1_ff <= `ECT_BYTE_RST;
      edge_sel_ff <= `ECT_EDG_OFF;
      trig_mode_enable_ff <= 1'b0;
      internal_clock_pick_ff <= 1'b0;
    end
    else if (wr_ctl1)
      ctl1_ff <= I_WDATA;
    else if (wr_ctl2)
    begin
      edge_sel_ff <= I_WDATA[`ECT_C2_EDGE_HI:`ECT_C2_EDGE_LO];
      trig_mode_enable_ff <= I_WDATA[`ECT_C2_TRIGGER_MODE_ENABLE];
      internal_clock_pick_ff <= I_WDATA[`ECT_C2_ICK];
    end
  end

  always_ff @(posedge I_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      act_a_ff <= `ECT_ACT_NONE;
      act_b_ff <= `ECT_ACT_NONE;
    end
    else if (wr_stat)
    begin
      act_a_ff <= I_WDATA[`ECT_ST_ACTA_HI:`ECT_ST_ACTA_LO];
      act_b_ff <= I_WDATA[`ECT_ST_ACTB_HI:`ECT_ST_ACTB_LO];
    end
  end

  always_ff @(posedge I_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      match_value_a_ff <= `ECT_MVAL_RST;
      match_value_b_ff <= `ECT_MVAL_RST;
    end
    else
    begin
      match_value_a_ff <= wr_mva ? I_WDATA : match_value_a_ff;
      match_value_b_ff <= wr_mvb ? I_WDATA : match_value_b_ff;
    end
  end

  always_ff @(posedge I_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      up_counter_ff <= `ECT_BYTE_RST;
      run_ff <= ECT_RUN;
      div_ff <= '0;
      int_prev_ff <= 1'b0;
      pin_prev_ff <= 3'h0;
    end
    else
    begin
      up_counter_ff <= nxt_up_counter;
      run_ff <= nxt_run;
      div_ff <= nxt_div;
      int_prev_ff <= int_clk;
      pin_prev_ff <= pin_lvl;
    end
  end

  always_ff @(posedge I_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      flags_ff <= 3'h0;
      arm_ff <= 3'h0;
      out_ff <= 1'b0; // R22
      rdata_ff <= `ECT_BYTE_RST;
      seen_match_ff <= 1'b0;
    end
    else
    begin
      flags_ff <= nxt_flags;
      arm_ff <= nxt_arm;
      out_ff <= nxt_out;
      rdata_ff <= nxt_rdata;
      seen_match_ff <= seen_match_ff || match_a || match_b;
    end
  end

  assign O_RDATA = rdata_ff;
  assign O_TIMER_OUT_PIN = out_ff;
  assign O_IRQ_WRAP = flags_ff[0] && ctl1_ff[`ECT_C1_WIE]; // R3
  assign O_IRQ_MATCH_A = flags_ff[1] && ctl1_ff[`ECT_C1_MAIE]; // R6
  assign O_IRQ_MATCH_B = flags_ff[2] && ctl1_ff[`ECT_C1_MBIE]; // R6

  // ================================================================
  // Checks
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_ARST_N);

  wrap_flag_set_a: assert property ( // R2
    wrap_ev |=> flags_ff[0] && up_counter_ff == `ECT_BYTE_RST)
    else $error("wrap flag not set on wrap");
  wrap_irq_gate_a: assert property ( // R3
    $rose(O_IRQ_WRAP) |-> ctl1_ff[`ECT_C1_WIE]
      && ($past(wrap_ev) || $past(wr_ctl1)))
    else $error("wrap request without cause");
  match_a_flag_a: assert property ( // R4
    (tick && eq_a && !wr_mva) |=> flags_ff[1])
    else $error("match A flag not set");
  match_late_a: assert property ( // R5
    $rose(flags_ff[1]) |-> $past(tick) && $past(eq_a))
    else $error("match A flagged before last equal state");
  match_irq_gate_a: assert property ( // R6
    $rose(O_IRQ_MATCH_B) |-> ctl1_ff[`ECT_C1_MBIE])
    else $error("match B request while disabled");
  clear_on_b_a: assert property ( // R8
    (match_b && clr_sel == `ECT_CLR_B) |=> up_counter_ff == 8'h00)
    else $error("counter not cleared on match B");
  clear_on_pin_a: assert property ( // R9
    (rst_rise && clr_sel == `ECT_CLR_PIN) |=> up_counter_ff == 8'h00)
    else $error("counter not cleared by reset pin");
  trig_halt_a: assert property ( // R11
    (trig_mode_enable_ff && clr_any) |=> !running [*1] ##1
      (up_counter_ff == 8'h00 || running || $past(wr_cnt)))
    else $error("counting continued after trigger halt");
  trig_restart_a: assert property ( // R12
    (trig_mode_enable_ff && !running && trg_edge && !clr_any)
      |=> running)
    else $error("trigger edge did not restart counting");
  clear_over_write_a: assert property ( // R13
    (wr_cnt && clr_any) |=> up_counter_ff == 8'h00)
    else $error("write beat a clear");
  write_over_inc_a: assert property ( // R14
    (wr_cnt && !clr_any) |=> up_counter_ff == $past(I_WDATA))
    else $error("counter write lost");
  write_blocks_match_a: assert property ( // R15
    wr_mva |=> !$rose(flags_ff[1]))
    else $error("match A not suppressed by write");
  toggle_first_a: assert property ( // R16
    (match_a && match_b && (act_a_ff == `ECT_ACT_TOG
      || act_b_ff == `ECT_ACT_TOG)) |=> out_ff != $past(out_ff))
    else $error("toggle lost its priority");
  out_low_start_a: assert property ( // R22
    !seen_match_ff |-> !O_TIMER_OUT_PIN)
    else $error("output high before any match");
  flag_needs_read_a: assert property ( // R23
    (flags_ff[1] && !arm_ff[1] && !match_a) |=> flags_ff[1])
    else $error("flag cleared without prior read");

endmodule // ect_timer

/* sim/ect_pins.sv */
`timescale 1ns/1ps
// ==================================================================
// Far-side pin model: count clock, counter reset and trigger pins
module ect_pins
  (
  // Clock
  input wire logic i_clk,
  // Pins
  output logic o_ext_clk,
  output logic o_rst_pin,
  output logic o_trg_pin
  );
  initial
  begin
    o_ext_clk = 1'b0;
    o_rst_pin = 1'b0;
    o_trg_pin = 1'b0;
  end

  // Three clocks high and four low per pulse, so the agreement filter never drops one
  task automatic ext_pulses(input int n);
    repeat (n)
    begin
      @(posedge i_clk) o_ext_clk <= 1'b1;
      repeat (3) @(posedge i_clk);
      o_ext_clk <= 1'b0;
      repeat (3) @(posedge i_clk);
    end
  endtask

  task automatic rst_pulse();
    @(posedge i_clk) o_rst_pin <= 1'b1;
    repeat (3) @(posedge i_clk);
    o_rst_pin <= 1'b0;
  endtask

  task automatic trg_level(input logic v);
    @(posedge i_clk) o_trg_pin <= v;
  endtask
endmodule // ect_pins

/* sim/eight_bit_compare_timer_test.sv */
`timescale 1ns/1ps
`include "ect_map.svh"
module eight_bit_compare_timer_test
  import ect_pkg::*;
  ;
  logic I_CLK;
  logic I_ARST_N;
  logic I_WR;
  logic I_RD;
  logic [3:0] I_ADDR;
  ect_byte_t I_WDATA;
  ect_byte_t O_RDATA;
  logic I_EXT_CLK;
  logic I_COUNTER_RESET_PIN;
  logic I_TRIGGER_PIN;
  logic O_TIMER_OUT_PIN;
  logic O_IRQ_WRAP;
  logic O_IRQ_MATCH_A;
  logic O_IRQ_MATCH_B;
  int err_total = 0;
  int checked = 0;
  int cycles = 0;

  ect_timer u_dut (.I_CLK(I_CLK), .I_ARST_N(I_ARST_N), .I_ADDR(I_ADDR),
    .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
    .I_EXT_CLK(I_EXT_CLK), .I_COUNTER_RESET_PIN(I_COUNTER_RESET_PIN),
    .I_TRIGGER_PIN(I_TRIGGER_PIN), .O_TIMER_OUT_PIN(O_TIMER_OUT_PIN),
    .O_IRQ_WRAP(O_IRQ_WRAP), .O_IRQ_MATCH_A(O_IRQ_MATCH_A),
    .O_IRQ_MATCH_B(O_IRQ_MATCH_B));

  ect_pins u_pins (.i_clk(I_CLK), .o_ext_clk(I_EXT_CLK),
    .o_rst_pin(I_COUNTER_RESET_PIN), .o_trg_pin(I_TRIGGER_PIN));

  initial
  begin
    I_CLK = 1'b0;
    forever #20 I_CLK = ~I_CLK;
  end

  // ==================================================================
  // Reporting
  task automatic wrap_up();
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // The whole run needs well under 10000 cycles
  always @(posedge I_CLK)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      err_total++;
      wrap_up();
    end
  end

  task automatic chk(input string nm, input logic [7:0] exp,
                     input logic [7:0] got);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // ==================================================================
  // Register port
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge I_CLK);
    I_ADDR <= a;
    I_WDATA <= d;
    I_WR <= 1'b1;
    @(posedge I_CLK);
    I_WR <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge I_CLK);
    I_ADDR <= a;
    I_RD <= 1'b1;
    @(posedge I_CLK);
    I_RD <= 1'b0;
    #1 d = O_RDATA;
  endtask

  task automatic rchk(input logic [3:0] a, input logic [7:0] e,
                      input string nm);
    logic [7:0] d;
    rd(a, d);
    chk(nm, e, d);
  endtask

  task automatic wait_pin(input logic v, output int n);
    n = 0;
    while (O_TIMER_OUT_PIN !== v && n < 200)
    begin
      @(posedge I_CLK);
      #1 n++;
    end
  endtask

  // ==================================================================
  // Scenarios
  task automatic t_reset();
    rchk(`ECT_OFS_CTL1, 8'h00, "ctl1");
    rchk(`ECT_OFS_CTL2, 8'hE2, "ctl2");
    rchk(`ECT_OFS_STAT, 8'h10, "stat");
    rchk(`ECT_OFS_MVA, 8'hFF, "mva");
    rchk(`ECT_OFS_MVB, 8'hFF, "mvb");
    chk("out", 8'h00, O_TIMER_OUT_PIN);
    chk("irqs", 8'h00, {O_IRQ_WRAP, O_IRQ_MATCH_A, O_IRQ_MATCH_B});
    wr(4'hF, 8'hAA);
    rchk(4'hF, 8'h00, "unmapped");
    repeat (20) @(posedge I_CLK);
    rchk(`ECT_OFS_CNT, 8'h00, "stopped cnt");
  endtask

  task automatic t_ext();
    logic [7:0] d;
    for (int k = 3; k <= 5; k++)
    begin
      wr(`ECT_OFS_CTL1, 8'h00);
      wr(`ECT_OFS_CNT, 8'h00);
      wr(`ECT_OFS_CTL1, 8'(k));
      u_pins.ext_pulses(5);
      repeat (10) @(posedge I_CLK);
      rd(`ECT_OFS_CNT, d);
      chk("ext cnt", (k == 5) ? 8'h0A : 8'h05, d);
    end
    wr(`ECT_OFS_CTL1, 8'h00);
  endtask

  task automatic t_wrap();
    logic [7:0] d;
    wr(`ECT_OFS_CNT, 8'hFE);
    wr(`ECT_OFS_CTL1, 8'h01);
    d = 8'h00;
    for (int i = 0; i < 40 && !d[5]; i++)
      rd(`ECT_OFS_STAT, d);
    chk("wrap flag", 8'h01, d[5]);
    chk("wrap irq off", 8'h00, O_IRQ_WRAP);
    wr(`ECT_OFS_CTL1, 8'h21);
    #1 chk("wrap irq on", 8'h01, O_IRQ_WRAP);
    // Bit 5 written as 1 keeps the flag, and the write disarms all three flags
    wr(`ECT_OFS_STAT, 8'h20);
    wr(`ECT_OFS_STAT, 8'h00);
    #1 chk("unarmed clear", 8'h01, O_IRQ_WRAP);
    rd(`ECT_OFS_STAT, d);
    wr(`ECT_OFS_STAT, 8'h00);
    #1 chk("armed clear", 8'h00, O_IRQ_WRAP);
    wr(`ECT_OFS_CTL1, 8'h00);
  endtask

  task automatic t_wave();
    int n;
    logic [7:0] d;
    wr(`ECT_OFS_MVA, 8'h04);
    wr(`ECT_OFS_MVB, 8'h01);
    wr(`ECT_OFS_STAT, 8'h06);
    wr(`ECT_OFS_CNT, 8'h00);
    wr(`ECT_OFS_CTL1, 8'h49);
    wait_pin(1'b1, n);
    wait_pin(1'b0, n);
    chk("high time", 8'h08, n[7:0]);
    wait_pin(1'b1, n);
    chk("low time", 8'h0C, n[7:0]);
    chk("irq a", 8'h01, O_IRQ_MATCH_A);
    chk("irq b masked", 8'h00, O_IRQ_MATCH_B);
    rd(`ECT_OFS_STAT, d);
    chk("flag b", 8'h01, d[7]);
    rd(`ECT_OFS_CNT, d);
    chk("cnt in range", 8'h01, d <= 8'h04);
    wr(`ECT_OFS_CTL1, 8'h00);
  endtask

  task automatic t_prio();
    logic [1:0] ta [6] = '{2'h0, 2'h3, 2'h0, 2'h1, 2'h1, 2'h3};
    logic [1:0] tb [6] = '{2'h1, 2'h1, 2'h0, 2'h0, 2'h2, 2'h3};
    logic p;
    p = 1'b0;
    wr(`ECT_OFS_MVA, 8'h02);
    wr(`ECT_OFS_MVB, 8'h02);
    for (int i = 0; i < 6; i++)
    begin
      wr(`ECT_OFS_STAT, {4'h0, tb[i], ta[i]});
      wr(`ECT_OFS_CNT, 8'h01);
      wr(`ECT_OFS_CTL1, 8'h01);
      repeat (30) @(posedge I_CLK);
      if (ta[i] == 2'h3 || tb[i] == 2'h3)
        p = ~p;
      else if (ta[i] == 2'h2 || tb[i] == 2'h2)
        p = 1'b1;
      else if (ta[i] == 2'h1 || tb[i] == 2'h1)
        p = 1'b0;
      chk("action out", p, O_TIMER_OUT_PIN);
      wr(`ECT_OFS_CTL1, 8'h00);
    end
  endtask

  task automatic t_trig();
    logic [1:0] eg [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
    logic lv [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    logic go [4] = '{1'b1, 1'b1, 1'b1, 1'b0};
    logic [7:0] d;
    wr(`ECT_OFS_CNT, 8'h00);
    wr(`ECT_OFS_CTL1, 8'h19);
    for (int i = 0; i < 4; i++)
    begin
      wr(`ECT_OFS_CTL2, {3'h0, eg[i], 3'h4});
      u_pins.rst_pulse();
      // Lands on the edge where the pin clear fires
      wr(`ECT_OFS_CNT, 8'h33);
      repeat (20) @(posedge I_CLK);
      rd(`ECT_OFS_CNT, d);
      chk("halted cnt", 8'h00, d);
      u_pins.trg_level(lv[i]);
      repeat (20) @(posedge I_CLK);
      rd(`ECT_OFS_CNT, d);
      chk("restarted", go[i], d != 8'h00);
    end
    wr(`ECT_OFS_CTL1, 8'h00);
    wr(`ECT_OFS_CTL2, 8'h00);
  endtask

  task automatic t_pulse();
    int n;
    logic [7:0] d;
    wr(`ECT_OFS_MVA, 8'h02);
    wr(`ECT_OFS_MVB, 8'h05);
    wr(`ECT_OFS_STAT, 8'h06);
    wr(`ECT_OFS_CTL2, 8'h15);
    wr(`ECT_OFS_CNT, 8'h05);
    wr(`ECT_OFS_CTL1, 8'h11);
    repeat (20) @(posedge I_CLK);
    u_pins.trg_level(1'b1);
    repeat (12) @(posedge I_CLK);
    rd(`ECT_OFS_CNT, d);
    chk("rise ignored", 8'h00, d);
    chk("pulse idle", 8'h00, O_TIMER_OUT_PIN);
    u_pins.trg_level(1'b0);
    wait_pin(1'b1, n);
    chk("pulse delay", 8'h01, n >= 20 && n <= 31);
    wait_pin(1'b0, n);
    chk("pulse width", 8'h18, n[7:0]);
    repeat (20) @(posedge I_CLK);
    rd(`ECT_OFS_CNT, d);
    chk("halt after b", 8'h00, d);
    wr(`ECT_OFS_CTL1, 8'h00);
    wr(`ECT_OFS_CTL2, 8'h00);
    wr(`ECT_OFS_CNT, 8'h00);
    wr(`ECT_OFS_CTL1, 8'h02);
    repeat (80) @(posedge I_CLK);
    wr(`ECT_OFS_CTL1, 8'h00);
    rd(`ECT_OFS_CNT, d);
    chk("slow source", 8'h01, d >= 8'h02 && d <= 8'h03);
  endtask

  // ==================================================================
  // Main sequence
  initial
  begin
    I_ARST_N = 1'b0;
    I_WR = 1'b0;
    I_RD = 1'b0;
    I_ADDR = 4'h0;
    I_WDATA = 8'h00;
    repeat (2) @(posedge I_CLK);
    I_ARST_N <= 1'b1;
    t_reset();
    t_ext();
    t_wrap();
    t_wave();
    t_prio();
    t_trig();
    t_pulse();
    wrap_up();
  end
endmodule // eight_bit_compare_timer_test
